// *** core/uec_endpoint_ctrl.sv ***
// Endpoint control, status, FIFO data port and transceiver control of a USB device port.
`timescale 1ns/1ps
`default_nettype none
// What this block does
// R1: Software polls a written flag until it reads back before the next write.
// R2: In-acknowledged flag set on host ACK of IN data, cleared by writing zero.
// R3: Bank zero full flag set on packet stored, cleared by writing zero.
// R4: Firmware reads count bytes from FIFO then clears the bank flag.
// R5: Setup-received flag set on valid setup packet, cleared by writing zero.
// R6: OUT data refused while setup-received flag is set.
// R7: Stall-acknowledged flag set when host acknowledges STALL, cleared by writing zero.
// R8: On isochronous endpoints the same bit reports a CRC error instead.
// R9: Transmit ready set only by firmware writing one, cleared only by device.
// R10: Firmware checks transmit ready clear, loads bytes, sets it, awaits acknowledge.
// R11: Stall request bit makes the endpoint answer STALL; read shows stall state.
// R12: Second receive bank with its own flag behaving like bank zero.
// R13: Direction bit selects OUT (0) or IN (1) control data stage.
// R14: Three-bit endpoint kind field encodes control, iso, bulk, interrupt and direction.
// R15: Read-only toggle bit shows expected data PID, 0 DATA0, 1 DATA1.
// R16: Endpoint-on bit enables or disables the endpoint and reads back state.
// R17: Eleven-bit read-only count of received bytes in the FIFO.
// R18: Byte-wide FIFO data port: read pops received byte, write pushes payload.
// R19: Firmware never pushes more than max packet size or FIFO memory.
// R20: Transceiver-off bit powers down the transceiver, clearing re-enables it.
// R21: Software enables the port clock before touching any register.
// R22: SE0 on the lines is treated as a USB bus reset.
// R23: Sticky summary interrupt flag stays set while any endpoint flag is set.
// R24: Endpoint reset zeroes FIFO pointers, count and toggle, keeping flags.
// R25: Flag writes reach the flags after a transfer delay; read-back shows it later.
module uec_endpoint_ctrl
  import uec_pkg::*;
#(
  parameter int DEPTH_LOG2 = 6,
  parameter bit PINGPONG   = 1'b1
)(
  input  wire logic        clk,
  input  wire logic        rst_b,
  input  wire logic [4:0]  avm_address,
  input  wire logic        avm_read,
  input  wire logic        avm_write,
  input  wire logic [31:0] avm_writedata,
  output logic      [31:0] avm_readdata,
  output logic             avm_waitrequest,
  input  wire logic        link_rx_valid,
  input  wire logic [7:0]  link_rx_byte,
  input  wire logic        link_rx_is_setup,
  input  wire logic        link_rx_end,
  input  wire logic        link_in_ack,
  input  wire logic        link_stall_ack,
  input  wire logic        link_iso_crc_bad,
  input  wire logic        link_tx_pop,
  input  wire logic        link_toggle_flip,
  input  wire logic        se0_pin,
  output logic      [7:0]  link_tx_byte,
  output logic             out_accept,
  output logic             in_ready,
  output logic             stall_handshake,
  output logic             ctrl_dir,
  output logic             endpoint_irq_flag,
  output logic             phy_off,
  output logic             usb_bus_reset
);
  localparam int DEPTH = 1 << DEPTH_LOG2;

  logic [7:0]             rx_mem [DEPTH];
  logic [7:0]             tx_mem [DEPTH];
  logic [DEPTH_LOG2-1:0]  rx_wptr_q, rx_rptr_q, tx_wptr_q, tx_rptr_q;
  logic [UEC_COUNT_W-1:0] rx_count_q;
  logic                   in_sent_ack_flag_q, rx_bank0_full_q, rx_bank1_full_q;
  logic                   setup_received_q, stall_acked_q, tx_packet_ready_q;
  logic                   stall_request_q, toggle_bit_q, endpoint_on_q, dir_q;
  logic [2:0]             endpoint_kind_q;
  logic                   ep_reset_q, phy_off_q, se0_meta_q, se0_sync_q;
  logic                   is_iso;
  logic                   bus_done;
  logic                   fw_pop, fw_push;
  logic                   rx_take;
  logic [UEC_SYNC_STAGES-1:0] fl_vld_q;
  logic [31:0]            fl_data_q [UEC_SYNC_STAGES];
  logic                   fl_apply;
  logic [31:0]            fl_word;
  logic                   pend_clear;

  // Decode of the isochronous kinds, which repurpose the stall bit.
  function automatic logic kind_is_iso(input logic [2:0] kind);
    kind_is_iso = (kind[1:0] == UEC_KIND_ISO);
  endfunction

  assign is_iso     = kind_is_iso(endpoint_kind_q);
  assign bus_done   = (avm_read | avm_write) & ~avm_waitrequest;
  assign fw_pop     = bus_done & avm_read & (avm_address == UEC_FIFO_ADDR) & (rx_count_q != '0);
  assign fw_push    = bus_done & avm_write & (avm_address == UEC_FIFO_ADDR);
  assign rx_take    = link_rx_valid & out_accept;
  assign fl_apply   = fl_vld_q[UEC_SYNC_STAGES-1];
  assign fl_word    = fl_data_q[UEC_SYNC_STAGES-1];
  // A packet end with no free bank is dropped; the link must not have been accepting.
  assign pend_clear = ep_reset_q | usb_bus_reset;

  // One wait state per access, so read data is ready when waitrequest drops.
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      avm_waitrequest <= 1'b1;
    else if ((avm_read | avm_write) & avm_waitrequest)
      avm_waitrequest <= 1'b0;
    else
      avm_waitrequest <= 1'b1;
  end

  // Read data is captured in the wait cycle; unmapped addresses read zero.
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      avm_readdata <= UEC_ZERO_WORD;
    else if (avm_read & avm_waitrequest)
    begin
      avm_readdata <= UEC_ZERO_WORD;
      if (avm_address == UEC_CSR_ADDR)
      begin
        avm_readdata[UEC_B_INACK]  <= in_sent_ack_flag_q;
        avm_readdata[UEC_B_BK0]    <= rx_bank0_full_q;
        avm_readdata[UEC_B_SETUP]  <= setup_received_q;
        avm_readdata[UEC_B_STALL]  <= stall_acked_q;
        avm_readdata[UEC_B_TXRDY]  <= tx_packet_ready_q;
        avm_readdata[UEC_B_STREQ]  <= stall_request_q;                 // R11
        avm_readdata[UEC_B_BK1]    <= rx_bank1_full_q;
        avm_readdata[UEC_B_DIR]    <= dir_q;
        avm_readdata[UEC_B_KIND+:3] <= endpoint_kind_q;
        avm_readdata[UEC_B_TOGGLE] <= toggle_bit_q;                    // R15
        avm_readdata[UEC_B_ON]     <= endpoint_on_q;                   // R16
        avm_readdata[UEC_B_COUNT+:UEC_COUNT_W] <= rx_count_q;          // R17
      end
      else if (avm_address == UEC_FIFO_ADDR)
        avm_readdata[7:0] <= rx_mem[rx_rptr_q];                        // R18
      else if (avm_address == UEC_TXVC_ADDR)
        avm_readdata[UEC_B_PHYOFF] <= phy_off_q;
      else if (avm_address == UEC_EPRST_ADDR)
        avm_readdata[0] <= ep_reset_q;
      else if (avm_address == UEC_IRQ_ADDR)
        avm_readdata[0] <= endpoint_irq_flag;
    end
  end

  // Control register writes travel a short pipe before reaching the flags, so a
  // read straight after a write still shows the old value; software must poll.
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      fl_vld_q <= '0;
      for (int i = 0; i < UEC_SYNC_STAGES; i++)
        fl_data_q[i] <= UEC_ZERO_WORD;
    end
    else
    begin
      fl_vld_q[0]  <= bus_done & avm_write & (avm_address == UEC_CSR_ADDR);  // R25
      fl_data_q[0] <= avm_writedata;
      for (int i = 1; i < UEC_SYNC_STAGES; i++)
      begin
        fl_vld_q[i]  <= fl_vld_q[i-1];
        fl_data_q[i] <= fl_data_q[i-1];
      end
    end
  end

  // Hardware-set flags: the set wins when a clearing write lands in the same cycle.
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      in_sent_ack_flag_q <= 1'b0;
      setup_received_q   <= 1'b0;
      stall_acked_q      <= 1'b0;
    end
    else
    begin
      if (link_in_ack)
        in_sent_ack_flag_q <= 1'b1;                                    // R2
      else if (fl_apply & ~fl_word[UEC_B_INACK])
        in_sent_ack_flag_q <= 1'b0;
      if (link_rx_end & link_rx_is_setup)
        setup_received_q <= 1'b1;                                      // R5
      else if (fl_apply & ~fl_word[UEC_B_SETUP])
        setup_received_q <= 1'b0;
      if ((link_stall_ack & ~is_iso) | (link_iso_crc_bad & is_iso))
        stall_acked_q <= 1'b1;                                         // R7 R8
      else if (fl_apply & ~fl_word[UEC_B_STALL])
        stall_acked_q <= 1'b0;
    end
  end

  // Receive banks: bank zero first, bank one only when ping-pong is built in.
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      rx_bank0_full_q <= 1'b0;
      rx_bank1_full_q <= 1'b0;
    end
    else
    begin
      if (link_rx_end & ~link_rx_is_setup & out_accept & ~rx_bank0_full_q)
        rx_bank0_full_q <= 1'b1;                                       // R3
      else if (fl_apply & ~fl_word[UEC_B_BK0])
        rx_bank0_full_q <= 1'b0;
      if (PINGPONG & link_rx_end & ~link_rx_is_setup & out_accept & rx_bank0_full_q)
        rx_bank1_full_q <= 1'b1;                                       // R12
      else if (fl_apply & ~fl_word[UEC_B_BK1])
        rx_bank1_full_q <= 1'b0;
    end
  end

  // Transmit ready: a firmware one sets it, the link's acknowledge clears it.
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      tx_packet_ready_q <= 1'b0;
    else if (fl_apply & fl_word[UEC_B_TXRDY])
      tx_packet_ready_q <= 1'b1;                                       // R9
    else if (link_in_ack)
      tx_packet_ready_q <= 1'b0;
  end

  // Read/write configuration fields of the control register; a bus reset also clears endpoint-on.
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      stall_request_q <= 1'b0;
      dir_q           <= 1'b0;
      endpoint_kind_q <= UEC_KIND_RST;
      endpoint_on_q   <= 1'b0;
    end
    else if (usb_bus_reset)
      endpoint_on_q <= 1'b0;
    else if (fl_apply)
    begin
      stall_request_q <= fl_word[UEC_B_STREQ];                         // R11
      dir_q           <= fl_word[UEC_B_DIR];                           // R13
      endpoint_kind_q <= fl_word[UEC_B_KIND+:3];                       // R14
      endpoint_on_q   <= fl_word[UEC_B_ON];                            // R16
    end
  end

  // Side registers: transceiver power-down and endpoint reset, written directly.
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      phy_off_q  <= UEC_PHYOFF_RST;
      ep_reset_q <= 1'b0;
    end
    else if (bus_done & avm_write)
    begin
      if (avm_address == UEC_TXVC_ADDR)
        phy_off_q <= avm_writedata[UEC_B_PHYOFF];                      // R20
      else if (avm_address == UEC_EPRST_ADDR)
        ep_reset_q <= avm_writedata[0];
    end
  end

  // SE0 arrives from the pins and is resynchronised before use as a bus reset.
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      se0_meta_q    <= 1'b0;
      se0_sync_q    <= 1'b0;
      usb_bus_reset <= 1'b0;
    end
    else
    begin
      se0_meta_q    <= se0_pin;
      se0_sync_q    <= se0_meta_q;
      usb_bus_reset <= se0_sync_q;                                     // R22
    end
  end

  // Data toggle follows the link; an endpoint or bus reset forces DATA0.
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      toggle_bit_q <= 1'b0;
    else if (pend_clear)
      toggle_bit_q <= 1'b0;                                            // R24
    else if (link_toggle_flip)
      toggle_bit_q <= ~toggle_bit_q;                                   // R15
  end

  // Receive storage: the link writes, firmware pops through the data port.
  always_ff @(posedge clk)
  begin
    if (rx_take)
      rx_mem[rx_wptr_q] <= link_rx_byte;
  end

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      rx_wptr_q  <= '0;
      rx_rptr_q  <= '0;
      rx_count_q <= '0;
    end
    else if (pend_clear)
    begin
      rx_wptr_q  <= '0;                                                // R24
      rx_rptr_q  <= '0;
      rx_count_q <= '0;
    end
    else
    begin
      if (rx_take)
        rx_wptr_q <= rx_wptr_q + 1'b1;
      if (fw_pop)
        rx_rptr_q <= rx_rptr_q + 1'b1;                                 // R18
      if (rx_take & ~fw_pop)
        rx_count_q <= rx_count_q + 1'b1;                               // R17
      else if (fw_pop & ~rx_take)
        rx_count_q <= rx_count_q - 1'b1;
    end
  end

  // Transmit storage: firmware pushes, the link pops while sending an IN packet.
  // Overfilling past the memory wraps the pointer; firmware keeps within size.
  always_ff @(posedge clk)
  begin
    if (fw_push)
      tx_mem[tx_wptr_q] <= avm_writedata[7:0];                         // R18
  end

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      tx_wptr_q    <= '0;
      tx_rptr_q    <= '0;
      link_tx_byte <= 8'h00;
    end
    else if (pend_clear)
    begin
      tx_wptr_q    <= '0;                                              // R24
      tx_rptr_q    <= '0;
      link_tx_byte <= 8'h00;
    end
    else
    begin
      if (fw_push)
        tx_wptr_q <= tx_wptr_q + 1'b1;
      if (link_tx_pop & in_ready)
      begin
        link_tx_byte <= tx_mem[tx_rptr_q];
        tx_rptr_q    <= tx_rptr_q + 1'b1;
      end
    end
  end

  // Link-facing status, registered so the link sees clean levels.
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      out_accept        <= 1'b0;
      in_ready          <= 1'b0;
      stall_handshake   <= 1'b0;
      ctrl_dir          <= 1'b0;
      endpoint_irq_flag <= 1'b0;
      phy_off           <= UEC_PHYOFF_RST;
    end
    else
    begin
      out_accept <= endpoint_on_q & ~setup_received_q & ~stall_request_q &    // R6
                    (~rx_bank0_full_q | (PINGPONG & ~rx_bank1_full_q));
      in_ready          <= endpoint_on_q & tx_packet_ready_q & ~stall_request_q; // R9
      stall_handshake   <= stall_request_q;                            // R11
      ctrl_dir          <= dir_q & (endpoint_kind_q == UEC_KIND_CTRL); // R13
      endpoint_irq_flag <= in_sent_ack_flag_q | rx_bank0_full_q | rx_bank1_full_q |
                           setup_received_q | stall_acked_q;           // R23
      phy_off           <= phy_off_q;                                  // R20
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  inack_set_a: assert property (link_in_ack |=> in_sent_ack_flag_q) // R2
    else $error("in-acknowledged flag not set after host ack");
  inack_clear_a: assert property (fl_apply & ~fl_word[UEC_B_INACK] & ~link_in_ack
    |=> ~in_sent_ack_flag_q) // R2
    else $error("in-acknowledged flag not cleared by zero write");
  bank0_set_a: assert property (link_rx_end & ~link_rx_is_setup & out_accept & ~rx_bank0_full_q
    |=> rx_bank0_full_q) // R3
    else $error("bank zero flag not set on packet end");
  setup_refuse_a: assert property (setup_received_q |=> ~out_accept) // R6
    else $error("OUT accepted while setup pending");
  txrdy_hold_a: assert property (tx_packet_ready_q & ~link_in_ack & ~pend_clear
    |=> tx_packet_ready_q) // R9
    else $error("transmit ready dropped without acknowledge");
  write_lag_a: assert property (bus_done & avm_write & (avm_address == UEC_CSR_ADDR)
    |-> ##2 fl_apply) // R25
    else $error("flag write did not arrive after two cycles");
  toggle_rst_a: assert property (ep_reset_q |=> ~toggle_bit_q && rx_count_q == '0) // R24
    else $error("endpoint reset did not clear toggle and count");
  irq_sum_a: assert property (setup_received_q |=> endpoint_irq_flag) // R23
    else $error("summary flag missing while setup pending");
  phy_off_a: assert property (bus_done & avm_write & (avm_address == UEC_TXVC_ADDR)
    |-> ##2 phy_off == $past(avm_writedata[UEC_B_PHYOFF], 2)) // R20
    else $error("transceiver off bit not applied");
  stall_out_a: assert property ($rose(stall_request_q) |=> stall_handshake) // R11
    else $error("stall request not presented to link");
  wait_one_a: assert property ((avm_read | avm_write) & avm_waitrequest
    |=> ~avm_waitrequest)
    else $error("slave did not answer after one wait state");

  setup_seen_c: cover property (link_rx_end & link_rx_is_setup ##[1:20] fl_apply);
  bank1_used_c: cover property (rx_bank0_full_q & rx_bank1_full_q);
  in_done_c: cover property (in_ready ##[1:50] link_in_ack);
  iso_err_c: cover property (is_iso & link_iso_crc_bad);
endmodule
`default_nettype wire

// *** core/uec_pkg.sv ***
// Package with register map, field positions and constants of the endpoint controller.
package uec_pkg;
  // Register byte addresses on the Avalon-MM slave.
  localparam logic [4:0] UEC_CSR_ADDR   = 5'h00;
  localparam logic [4:0] UEC_FIFO_ADDR  = 5'h04;
  localparam logic [4:0] UEC_TXVC_ADDR  = 5'h08;
  localparam logic [4:0] UEC_EPRST_ADDR = 5'h0C;
  localparam logic [4:0] UEC_IRQ_ADDR   = 5'h10;
  // Control and status register field positions, plus the transceiver-off bit of its own register.
  localparam int UEC_B_INACK  = 0;
  localparam int UEC_B_BK0    = 1;
  localparam int UEC_B_SETUP  = 2;
  localparam int UEC_B_STALL  = 3;
  localparam int UEC_B_TXRDY  = 4;
  localparam int UEC_B_STREQ  = 5;
  localparam int UEC_B_BK1    = 6;
  localparam int UEC_B_DIR    = 7;
  localparam int UEC_B_KIND   = 8;
  localparam int UEC_B_TOGGLE = 11;
  localparam int UEC_B_ON     = 15;
  localparam int UEC_B_COUNT  = 16;
  localparam int UEC_B_PHYOFF = 8;
  localparam int UEC_COUNT_W  = 11;
  // Endpoint kind encodings.
  localparam logic [2:0] UEC_KIND_CTRL = 3'h0;
  localparam logic [1:0] UEC_KIND_ISO  = 2'h1;
  // Reset values.
  localparam logic [2:0]  UEC_KIND_RST   = 3'h0;
  localparam logic        UEC_PHYOFF_RST = 1'b0;
  localparam logic [31:0] UEC_ZERO_WORD  = 32'h0000_0000;
  // Stages a flag write travels before it takes effect.
  localparam int UEC_SYNC_STAGES = 2;
endpackage

// *** tb/uec_host_model.sv ***
// Behavioural USB host side that drives the link strobes of the endpoint.
`timescale 1ns/1ps
`default_nettype none
module uec_host_model (
  input  wire logic       clk,
  input  wire logic [7:0] link_tx_byte,
  output logic            link_rx_valid,
  output logic [7:0]      link_rx_byte,
  output logic            link_rx_is_setup,
  output logic            link_rx_end,
  output logic            link_in_ack,
  output logic            link_stall_ack,
  output logic            link_iso_crc_bad,
  output logic            link_tx_pop,
  output logic            link_toggle_flip,
  output logic            se0_pin
);
  logic [7:0] got_q [$];
  // Everything idles low at time zero.
  initial
  begin
    {link_rx_valid, link_rx_is_setup, link_rx_end, link_in_ack} = 4'h0;
    {link_stall_ack, link_iso_crc_bad, link_tx_pop, link_toggle_flip, se0_pin} = 5'h00;
    link_rx_byte = 8'h00;
  end
  // Sends n bytes counting up from start, then the good-end pulse.
  task automatic send_pkt(input int n, input logic setup, input logic [7:0] start);
    for (int i = 0; i < n; i++)
    begin
      @(posedge clk);
      link_rx_valid <= 1'b1;
      link_rx_byte <= start + 8'(i);
      link_rx_is_setup <= setup;
    end
    @(posedge clk);
    link_rx_valid <= 1'b0;
    // Released data must not look like the last byte.
    link_rx_byte <= ~link_rx_byte;
    link_rx_end <= 1'b1;
    @(posedge clk);
    link_rx_end <= 1'b0;
    link_rx_is_setup <= 1'b0;
  endtask
  // Pulls n bytes, one request every three cycles, then acknowledges the packet.
  task automatic in_tx(input int n);
    for (int i = 0; i < n; i++)
    begin
      @(posedge clk);
      link_tx_pop <= 1'b1;
      @(posedge clk);
      link_tx_pop <= 1'b0;
      @(posedge clk);
      got_q.push_back(link_tx_byte);
    end
    @(posedge clk);
    link_in_ack <= 1'b1;
    @(posedge clk);
    link_in_ack <= 1'b0;
  endtask
  // One event strobe held for len cycles: 0 stall ack, 1 crc error, 2 toggle, else SE0.
  task automatic strobe(input int k, input int len);
    @(posedge clk);
    case (k)
      0: link_stall_ack <= 1'b1;
      1: link_iso_crc_bad <= 1'b1;
      2: link_toggle_flip <= 1'b1;
      default: se0_pin <= 1'b1;
    endcase
    repeat (len) @(posedge clk);
    {link_stall_ack, link_iso_crc_bad, link_toggle_flip, se0_pin} <= 4'h0;
  endtask
endmodule
`default_nettype wire

// *** tb/usb_endpoint_ctrl_tb.sv ***
// Self-checking bench of the endpoint controller against a behavioural host.
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) \
  begin \
    checked++; \
    if ((g) !== (e)) \
    begin \
      failures++; \
      $display("BAD %0t compare got %0h exp %0h", $time, g, e); \
    end \
  end
module usb_endpoint_ctrl_tb
  import uec_pkg::*;
;
  localparam logic [31:0] M_ON  = 32'h1 << UEC_B_ON;
  localparam logic [31:0] M_DIR = 32'h1 << UEC_B_DIR;
  localparam logic [31:0] M_SET = 32'h1 << UEC_B_SETUP;
  localparam logic [31:0] M_BK0 = 32'h1 << UEC_B_BK0;
  localparam logic [31:0] M_BK1 = 32'h1 << UEC_B_BK1;
  localparam logic [31:0] M_ACK = 32'h1 << UEC_B_INACK;
  localparam logic [31:0] M_STL = 32'h1 << UEC_B_STALL;
  localparam logic [31:0] M_TXR = 32'h1 << UEC_B_TXRDY;
  localparam logic [31:0] M_SRQ = 32'h1 << UEC_B_STREQ;
  logic        clk           = 1'b0;
  logic        rst_b         = 1'b0;
  logic [4:0]  avm_address   = 5'h00;
  logic        avm_read      = 1'b0;
  logic        avm_write     = 1'b0;
  logic [31:0] avm_writedata = 32'h0000_0000;
  logic [31:0] avm_readdata;
  logic        avm_waitrequest;
  logic        rx_valid, rx_setup, rx_end, in_ack, stall_ack, crc_bad, tx_pop, tgl, se0;
  logic [7:0]  rx_byte, tx_byte, b;
  logic        out_accept, in_ready, stall_handshake, ctrl_dir, endpoint_irq_flag;
  logic        phy_off, usb_bus_reset;
  logic        seen_rst      = 1'b0;
  logic [31:0] rdat, cfg;
  logic [31:0] rng_q         = 32'h0000_8B57;
  logic [7:0]  exp_q [$];
  logic [2:0]  kinds [7]     = '{3'h0, 3'h1, 3'h5, 3'h2, 3'h6, 3'h3, 3'h7};
  int          failures      = 0;
  int          checked       = 0;
  int          n1;
  int          n2;

  // Free-running 100 MHz clock.
  always #5 clk = ~clk;
  // The bus reset pulse is short, so it is caught here rather than polled.
  always @(posedge clk) if (usb_bus_reset === 1'b1) seen_rst <= 1'b1;

  uec_endpoint_ctrl uec_endpoint_ctrl_inst (.clk(clk), .rst_b(rst_b),
    .avm_address(avm_address), .avm_read(avm_read), .avm_write(avm_write),
    .avm_writedata(avm_writedata), .avm_readdata(avm_readdata),
    .avm_waitrequest(avm_waitrequest), .link_rx_valid(rx_valid), .link_rx_byte(rx_byte),
    .link_rx_is_setup(rx_setup), .link_rx_end(rx_end), .link_in_ack(in_ack),
    .link_stall_ack(stall_ack), .link_iso_crc_bad(crc_bad), .link_tx_pop(tx_pop),
    .link_toggle_flip(tgl), .se0_pin(se0), .link_tx_byte(tx_byte),
    .out_accept(out_accept), .in_ready(in_ready), .stall_handshake(stall_handshake),
    .ctrl_dir(ctrl_dir), .endpoint_irq_flag(endpoint_irq_flag), .phy_off(phy_off),
    .usb_bus_reset(usb_bus_reset));

  uec_host_model uec_host_model_inst (.clk(clk), .link_tx_byte(tx_byte),
    .link_rx_valid(rx_valid), .link_rx_byte(rx_byte), .link_rx_is_setup(rx_setup),
    .link_rx_end(rx_end), .link_in_ack(in_ack), .link_stall_ack(stall_ack),
    .link_iso_crc_bad(crc_bad), .link_tx_pop(tx_pop), .link_toggle_flip(tgl),
    .se0_pin(se0));

  // Xorshift generator for repeatable lengths and data.
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction

  // Prints the verdict and ends the run.
  task automatic stop_test;
    if (failures == 0 && checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  // One Avalon access held until waitrequest is seen low; read data lands in rdat.
  task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] wd);
    int n;
    @(posedge clk);
    avm_address <= a;
    avm_write <= wr;
    avm_read <= !wr;
    avm_writedata <= wd;
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (avm_waitrequest !== 1'b0 && n < 50);
    rdat = avm_readdata;
    avm_write <= 1'b0;
    avm_read <= 1'b0;
    if (n == 50)
    begin
      failures++;
      stop_test();
    end
  endtask

  // Writes the control word, then polls until the masked bits read back.
  task automatic csr_set(input logic [31:0] w, input logic [31:0] m);
    int n;
    bus(1'b1, UEC_CSR_ADDR, w);
    n = 0;
    do
    begin
      bus(1'b0, UEC_CSR_ADDR, 32'h0);
      n++;
    end
    while ((rdat & m) !== (w & m) && n < 20);
    `CHK(rdat & m, w & m)
  endtask

  // Host sends a random packet and the bytes are queued as expected.
  task automatic host_pkt(input logic setup, output int n);
    rng_q = xs(rng_q);
    n = 1 + int'(rng_q[11:8]);
    for (int i = 0; i < n; i++) exp_q.push_back(rng_q[7:0] + 8'(i));
    uec_host_model_inst.send_pkt(n, setup, rng_q[7:0]);
  endtask

  // Firmware drains n bytes through the data port.
  task automatic drain(input int n);
    for (int i = 0; i < n; i++)
    begin
      bus(1'b0, UEC_FIFO_ADDR, 32'h0);
      b = exp_q.pop_front();
      `CHK(rdat[7:0], b)
    end
  endtask

  // Main sequence.
  initial
  begin
    repeat (12) @(posedge clk);
    rst_b <= 1'b1;
    bus(1'b0, UEC_CSR_ADDR, 32'h0);
    `CHK(rdat, UEC_ZERO_WORD)
    bus(1'b1, 5'h14, 32'hFFFF_FFFF);
    bus(1'b0, 5'h14, 32'h0);
    `CHK(rdat, UEC_ZERO_WORD)
    cfg = M_ON;
    csr_set(cfg, M_ON);
    `CHK(out_accept, 1'b1)
    host_pkt(1'b1, n1);
    bus(1'b0, UEC_CSR_ADDR, 32'h0);
    `CHK(rdat & (M_SET | M_BK0), M_SET)
    `CHK(rdat[26:16], 11'(n1))
    `CHK(out_accept, 1'b0)
    bus(1'b0, UEC_IRQ_ADDR, 32'h0);
    `CHK(rdat[0], 1'b1)
    drain(n1);
    uec_host_model_inst.send_pkt(4, 1'b0, 8'hA5);
    cfg = M_ON | M_DIR;
    csr_set(cfg, M_SET | M_DIR);
    `CHK(ctrl_dir, 1'b1)
    `CHK(endpoint_irq_flag, 1'b0)
    cfg = M_ON;
    csr_set(cfg, M_DIR);
    for (int k = 0; k < 3; k++)
    begin
      host_pkt(1'b0, n1);
      host_pkt(1'b0, n2);
      bus(1'b0, UEC_CSR_ADDR, 32'h0);
      `CHK(rdat & (M_BK0 | M_BK1), M_BK0 | M_BK1)
      `CHK(rdat[26:16], 11'(n1 + n2))
      `CHK({out_accept, endpoint_irq_flag}, 2'b01)
      drain(n1 + n2);
      csr_set(cfg, M_BK0 | M_BK1);
    end
    bus(1'b1, UEC_CSR_ADDR, cfg | M_ACK | M_BK0 | M_BK1 | M_SET | M_STL);
    repeat (4) @(posedge clk);
    bus(1'b0, UEC_CSR_ADDR, 32'h0);
    `CHK(rdat & (M_ACK | M_BK0 | M_BK1 | M_SET | M_STL), 32'h0)
    `CHK(rdat & M_TXR, 32'h0)
    rng_q = xs(rng_q);
    n1 = 1 + int'(rng_q[3:0]);
    for (int i = 0; i < n1; i++) bus(1'b1, UEC_FIFO_ADDR, {24'h0, rng_q[15:8] ^ 8'(i)});
    csr_set(cfg | M_TXR, M_TXR);
    bus(1'b1, UEC_CSR_ADDR, cfg);
    repeat (4) @(posedge clk);
    bus(1'b0, UEC_CSR_ADDR, 32'h0);
    `CHK(rdat & (M_TXR | M_ACK), M_TXR)
    `CHK(in_ready, 1'b1)
    uec_host_model_inst.in_tx(n1);
    for (int i = 0; i < n1; i++) `CHK(uec_host_model_inst.got_q[i], rng_q[15:8] ^ 8'(i))
    bus(1'b0, UEC_CSR_ADDR, 32'h0);
    `CHK(rdat & (M_ACK | M_TXR), M_ACK)
    csr_set(cfg, M_ACK);
    csr_set(cfg | M_SRQ, M_SRQ);
    `CHK({stall_handshake, out_accept}, 2'b10)
    uec_host_model_inst.strobe(0, 1);
    bus(1'b0, UEC_CSR_ADDR, 32'h0);
    `CHK({rdat & M_STL, endpoint_irq_flag}, {M_STL, 1'b1})
    csr_set(cfg, M_SRQ | M_STL);
    `CHK(stall_handshake, 1'b0)
    for (int k = 0; k < 7; k++)
    begin
      csr_set(M_ON | M_DIR | (32'(kinds[k]) << UEC_B_KIND), M_DIR | (32'h7 << UEC_B_KIND));
      `CHK(ctrl_dir, kinds[k] == UEC_KIND_CTRL)
      if (k == 1)
      begin
        uec_host_model_inst.strobe(1, 1);
        bus(1'b0, UEC_CSR_ADDR, 32'h0);
        `CHK(rdat & M_STL, M_STL)
        csr_set(M_ON | M_DIR | 32'h100, M_STL);
      end
    end
    csr_set(cfg, M_DIR | (32'h7 << UEC_B_KIND));
    uec_host_model_inst.strobe(2, 1);
    host_pkt(1'b0, n1);
    bus(1'b0, UEC_CSR_ADDR, 32'h0);
    `CHK(rdat[UEC_B_TOGGLE], 1'b1)
    bus(1'b1, UEC_EPRST_ADDR, 32'h1);
    bus(1'b1, UEC_EPRST_ADDR, 32'h0);
    repeat (4) @(posedge clk);
    bus(1'b0, UEC_CSR_ADDR, 32'h0);
    `CHK({rdat[UEC_B_TOGGLE], rdat[26:16], rdat[UEC_B_BK0]}, {12'h000, 1'b1})
    exp_q.delete();
    csr_set(cfg, M_BK0);
    bus(1'b1, UEC_TXVC_ADDR, 32'h0000_0100);
    bus(1'b0, UEC_TXVC_ADDR, 32'h0);
    `CHK({rdat, phy_off}, {32'h0000_0100, 1'b1})
    bus(1'b1, UEC_TXVC_ADDR, 32'h0);
    bus(1'b0, UEC_TXVC_ADDR, 32'h0);
    `CHK({rdat, phy_off}, {32'h0, 1'b0})
    csr_set(32'h0, M_ON);
    `CHK(out_accept, 1'b0)
    csr_set(cfg, M_ON);
    uec_host_model_inst.strobe(3, 6);
    repeat (4) @(posedge clk);
    bus(1'b0, UEC_CSR_ADDR, 32'h0);
    `CHK({seen_rst, rdat[UEC_B_ON]}, 2'b10)
    stop_test();
  end
endmodule
`default_nettype wire
